// >>> core/tsm_device.sv
`timescale 1ns/1ps
module tsm_device
  import tsm_pkg::*;
#(
  parameter int CONV_CYC = CONV_CYCLES,
  parameter int NV_CYC   = NV_WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Two-wire bus
  twi_if.device                  bus,
  // Address select pins and write protect
  input  wire logic              select_bit_zero,
  input  wire logic              select_bit_one,
  input  wire logic              select_bit_two,
  input  wire logic              wp,
  // Temperature sensor result
  input  wire logic [TEMP_W-1:0] temp_code,
  // Status
  output logic [6:0]             lut_index,
  output logic                   standby
);
  localparam int CVW = $clog2(CONV_CYC + 1);
  localparam int NVW = $clog2(NV_CYC + 1);

  typedef enum logic [2:0] {
    D_IDLE, D_ADDR, D_ACK, D_WADDR, D_WDATA, D_READ, D_RACK, D_WAIT
  } dev_state_e;

  typedef struct packed {
    dev_state_e         st;
    dev_state_e         nxt;
    logic [3:0]         cnt;
    logic [7:0]         sr;
    logic               sda_oe;
    logic [7:0]         ptr;
    logic [7:0]         base;
    logic [3:0]         wcount;
    logic [3:0]         ccount;
    logic [3:0]         commit_i;
    logic [7:0][7:0]    stage;
    logic               nv_busy;
    logic [NVW-1:0]     nv_cnt;
    logic [CVW-1:0]     conv_cnt;
    logic [TEMP_W-1:0]  temp;
    logic [6:0]         idx;
    logic [3:0]         pin_m;
    logic [3:0]         pin_s;
  } dev_s;

  dev_s       q;
  dev_s       d;
  logic [7:0] mem_q [256];
  logic       mem_we;
  logic [7:0] mem_addr;
  logic [7:0] rd_byte;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       sda_s;
  logic       wp_s;
  logic       bus_active;

  twi_line_sampler u_sampler (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .scl       (bus.scl),
    .sda       (bus.sda),
    .scl_s     (),
    .sda_s     (sda_s),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  // ---------------------------------------------------------------------------
  // Read data selection
  // ---------------------------------------------------------------------------
  // The result bytes and the table index are live state, not memory cells.
  assign rd_byte = (q.ptr == TEMP_HI_ADDR) ? q.temp[TEMP_W-1 -: 8] :
                   (q.ptr == TEMP_LO_ADDR) ? {q.temp[TEMP_INT_LSB:0], 3'h0} :
                   (q.ptr == LUT_IDX_ADDR) ? {1'h0, q.idx} : mem_q[q.ptr];
  assign wp_s       = q.pin_s[3];
  assign mem_addr   = 8'(q.base + {4'h0, q.commit_i});
  assign bus_active = (q.st != D_IDLE) && (q.st != D_WAIT) && (q.st != D_ADDR);

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    int u;
    u      = 0;
    d      = q;
    mem_we = 1'b0;
    d.pin_m = {wp, select_bit_two, select_bit_one, select_bit_zero};
    d.pin_s = q.pin_m;

    // Conversion: first one right after reset, paused from the address acknowledge to the end of the access.
    if (!bus_active) begin
      if (q.conv_cnt == '0) begin
        d.conv_cnt = CVW'(CONV_CYC - 1);
        d.temp     = temp_code;
        u = int'($signed(temp_code[TEMP_W-1:TEMP_INT_LSB])) + LUT_BASE_DEGC;
        if (u >= STEP_DEGC * (int'(q.idx) + 1) + HYST_DEGC && q.idx != LUT_IDX_MAX) begin
          d.idx = 7'(q.idx + 7'h1);
        end else if (u < STEP_DEGC * int'(q.idx) - HYST_DEGC && q.idx != 7'h0) begin
          d.idx = 7'(q.idx - 7'h1);
        end
      end else begin
        d.conv_cnt = CVW'(q.conv_cnt - 1'b1);
      end
    end

    // Timed nonvolatile write: one staged byte per cycle, busy for the full time.
    if (q.nv_busy) begin
      if (q.commit_i < q.ccount) begin
        mem_we     = 1'b1;
        d.commit_i = 4'(q.commit_i + 4'h1);
      end
      if (q.nv_cnt == '0) begin
        d.nv_busy = 1'b0;
      end else begin
        d.nv_cnt = NVW'(q.nv_cnt - 1'b1);
      end
    end

    if (start_det) begin
      d.st     = D_ADDR;
      d.cnt    = 4'h0;
      d.sda_oe = 1'b0;
      d.wcount = 4'h0;
    end else if (stop_det) begin
      d.st     = D_IDLE;
      d.sda_oe = 1'b0;
      d.wcount = 4'h0;
      if (q.wcount != 4'h0 && !wp_s && !q.nv_busy) begin
        d.nv_busy  = 1'b1;
        d.nv_cnt   = NVW'(NV_CYC - 1);
        d.ccount   = q.wcount;
        d.commit_i = 4'h0;
      end
    end else begin
      case (q.st)
        D_ADDR, D_WADDR, D_WDATA: begin
          if (scl_rise) begin
            d.sr  = {q.sr[6:0], sda_s};
            d.cnt = 4'(q.cnt + 4'h1);
          end
          if (scl_fall && q.cnt == BYTE_BITS) begin
            d.sda_oe = 1'b1;
            d.st     = D_ACK;
            if (q.st == D_ADDR) begin
              if (q.sr[7:4] == CTRL_CODE && q.sr[3:1] == q.pin_s[2:0] && !q.nv_busy) begin
                d.nxt = q.sr[0] ? D_READ : D_WADDR;
              end else begin
                d.sda_oe = 1'b0;
                d.st     = D_WAIT;
              end
            end else if (q.st == D_WADDR) begin
              d.ptr  = q.sr;
              d.base = q.sr;
              d.nxt  = D_WDATA;
            end else begin
              d.ptr = 8'(q.ptr + 8'h1);
              d.nxt = D_WDATA;
              if (q.wcount < PAGE_BYTES) begin
                d.stage[q.wcount[2:0]] = q.sr;
                d.wcount               = 4'(q.wcount + 4'h1);
              end
            end
          end
        end
        D_ACK: begin
          if (scl_fall) begin
            d.cnt    = 4'h0;
            d.st     = q.nxt;
            d.sda_oe = 1'b0;
            if (q.nxt == D_READ) begin
              d.sr     = rd_byte;
              d.ptr    = 8'(q.ptr + 8'h1);
              d.sda_oe = !rd_byte[7];
            end
          end
        end
        D_READ: begin
          if (scl_rise) begin
            d.cnt = 4'(q.cnt + 4'h1);
          end
          if (scl_fall) begin
            if (q.cnt == BYTE_BITS) begin
              d.sda_oe = 1'b0;
              d.st     = D_RACK;
            end else begin
              d.sr     = {q.sr[6:0], 1'b0};
              d.sda_oe = !q.sr[6];
            end
          end
        end
        D_RACK: begin
          if (scl_rise) begin
            d.nxt = D_READ;
            d.st  = sda_s ? D_WAIT : D_ACK;
          end
        end
        D_IDLE, D_WAIT: begin
          d.sda_oe = 1'b0;
        end
        default: begin
          d.st     = D_IDLE;
          d.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // State registers and memory
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '{st: D_IDLE, nxt: D_IDLE, default: '0};
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge aclk) begin
    if (mem_we) begin
      mem_q[mem_addr] <= q.stage[q.commit_i[2:0]];
    end
  end

  assign bus.sda_d_o  = 1'b0;
  assign bus.sda_d_oe = q.sda_oe;
  assign lut_index    = q.idx;
  assign standby      = (q.st == D_IDLE || q.st == D_WAIT) && !q.nv_busy;
endmodule : tsm_device

// >>> core/tsm_pkg.sv
package tsm_pkg;
  localparam int         CLK_PERIOD_NS   = 4;
  localparam int         CONV_PERIOD_MS  = 10;
  localparam int         CONV_CYCLES     = CONV_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int         NV_WRITE_US     = 5000;
  localparam int         NV_WRITE_CYCLES = NV_WRITE_US * 1000 / CLK_PERIOD_NS;
  localparam int         LINK_PERIOD_NS  = 64;
  localparam int         QUARTER_CYCLES  = LINK_PERIOD_NS / CLK_PERIOD_NS / 4;
  localparam logic [3:0] CTRL_CODE       = 4'hA;
  localparam logic [3:0] BYTE_BITS       = 4'h8;
  localparam logic [3:0] RECOVER_CLOCKS  = 4'h9;
  localparam logic [3:0] PAGE_BYTES      = 4'h8;
  localparam logic [7:0] TEMP_HI_ADDR    = 8'hE2;
  localparam logic [7:0] TEMP_LO_ADDR    = 8'hE3;
  localparam logic [7:0] LUT_IDX_ADDR    = 8'hE4;
  localparam int         TEMP_W          = 13;
  localparam int         TEMP_INT_LSB    = 4;
  localparam int         LUT_BASE_DEGC   = 40;
  localparam int         STEP_DEGC       = 2;
  localparam int         HYST_DEGC       = 1;
  localparam logic [6:0] LUT_IDX_MAX     = 7'h47;
  localparam logic [3:0] CMD_OFFSET      = 4'h0;
  localparam logic [3:0] STATUS_OFFSET   = 4'h4;
  localparam int         STATUS_BUSY_BIT = 0;
  localparam int         STATUS_NACK_BIT = 1;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

  typedef enum logic [2:0] {
    CMD_NONE, CMD_START, CMD_STOP, CMD_WRITE, CMD_READ_ACK, CMD_READ_NACK, CMD_RECOVER
  } twi_cmd_e;
endpackage : tsm_pkg

// >>> core/twi_if.sv
`timescale 1ns/1ps
interface twi_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic scl;
  logic sda;

  // Open-drain lines with a pull-up: any enabled low driver wins.
  assign scl = !(scl_m_oe && !scl_m_o);
  assign sda = !(sda_m_oe && !sda_m_o) && !(sda_d_oe && !sda_d_o);

  modport master (input scl, input sda, output scl_m_o, output scl_m_oe, output sda_m_o, output sda_m_oe);
  modport device (input scl, input sda, output sda_d_o, output sda_d_oe);
endinterface : twi_if

// >>> core/twi_line_sampler.sv
`timescale 1ns/1ps
module twi_line_sampler (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Raw lines
  input  wire logic scl,
  input  wire logic sda,
  // Synchronised levels and events
  output logic      scl_s,
  output logic      sda_s,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start_det,
  output logic      stop_det
);
  typedef struct packed {
    logic [1:0] m;
    logic [1:0] s;
    logic [1:0] p;
  } smp_s;

  smp_s q;
  smp_s d;

  always_comb begin
    d   = q;
    d.m = {scl, sda};
    d.s = q.m;
    d.p = q.s;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '{m: 2'h3, s: 2'h3, p: 2'h3};
    end else begin
      q <= d;
    end
  end

  assign scl_s     = q.s[1];
  assign sda_s     = q.s[0];
  assign scl_rise  = q.s[1] && !q.p[1];
  assign scl_fall  = !q.s[1] && q.p[1];
  assign start_det = q.s[1] && q.p[1] && q.p[0] && !q.s[0];
  assign stop_det  = q.s[1] && q.p[1] && !q.p[0] && q.s[0];
endmodule : twi_line_sampler

// >>> core/twi_master_ctrl.sv
`timescale 1ns/1ps
module twi_master_ctrl
  import tsm_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYCLES
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Two-wire bus
  twi_if.master            bus
);
  localparam int DW = $clog2(QUARTER + 1);

  typedef struct packed {
    twi_cmd_e    op;
    logic [1:0]  ph;
    logic [DW-1:0] div;
    logic [3:0]  bit_i;
    logic [7:0]  tx;
    logic [7:0]  rx;
    logic        nack;
    logic        found;
    logic        scl_lo;
    logic        sda_lo;
    logic        aw_got;
    logic        w_got;
    logic [3:0]  aw_q;
    logic [15:0] w_q;
    logic [1:0]  ws_q;
    logic [15:0] cmd;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } mst_s;

  mst_s        q;
  mst_s        d;
  logic        sda_s;
  logic [31:0] status;

  twi_line_sampler u_sampler (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .scl       (bus.scl),
    .sda       (bus.sda),
    .scl_s     (),
    .sda_s     (sda_s),
    .scl_rise  (),
    .scl_fall  (),
    .start_det (),
    .stop_det  ()
  );

  assign status = {16'h0, q.rx, 6'h0, q.nack, q.op != CMD_NONE};
  assign awready = !q.aw_got && !q.bvalid;
  assign wready  = !q.w_got && !q.bvalid;
  assign arready = !q.rvalid;

  always_comb begin
    d = q;
    // -------------------------------------------------------------------------
    // Register access
    // -------------------------------------------------------------------------
    if (awvalid && awready) begin
      d.aw_got = 1'b1;
      d.aw_q   = awaddr;
    end
    if (wvalid && wready) begin
      d.w_got = 1'b1;
      d.w_q   = wdata[15:0];
      d.ws_q  = wstrb[1:0];
    end
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (q.aw_got && q.w_got) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = RESP_OKAY;
      if (q.aw_q == CMD_OFFSET) begin
        if (q.op == CMD_NONE && q.ws_q[0]) begin
          d.cmd    = {q.ws_q[1] ? q.w_q[15:8] : q.cmd[15:8], q.w_q[7:0]};
          d.op     = twi_cmd_e'(q.w_q[2:0]);
          d.tx     = d.cmd[15:8];
          d.ph     = 2'h0;
          d.div    = DW'(QUARTER - 1);
          d.bit_i  = 4'h0;
          d.nack   = 1'b0;
          d.found  = 1'b0;
        end
      end else if (q.aw_q != STATUS_OFFSET) begin
        d.bresp = RESP_SLVERR;
      end
    end
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      if (araddr == CMD_OFFSET) begin
        d.rdata = {16'h0, q.cmd};
      end else if (araddr == STATUS_OFFSET) begin
        d.rdata = status;
      end else begin
        d.rdata = 32'h0;
        d.rresp = RESP_SLVERR;
      end
    end
    // -------------------------------------------------------------------------
    // Bit engine: four quarter phases per clock pulse
    // -------------------------------------------------------------------------
    if (q.op != CMD_NONE) begin
      if (q.div != '0) begin
        d.div = DW'(q.div - 1'b1);
      end else begin
        d.div = DW'(QUARTER - 1);
        d.ph  = 2'(q.ph + 2'h1);
        case (q.op)
          CMD_START: begin
            if (q.ph == 2'h0) begin
              d.sda_lo = 1'b0;
            end else if (q.ph == 2'h1) begin
              d.scl_lo = 1'b0;
            end else if (q.ph == 2'h2) begin
              d.sda_lo = 1'b1;
            end else begin
              d.scl_lo = 1'b1;
              d.op     = CMD_NONE;
            end
          end
          CMD_STOP: begin
            if (q.ph == 2'h0) begin
              d.sda_lo = 1'b1;
            end else if (q.ph == 2'h1) begin
              d.scl_lo = 1'b0;
            end else if (q.ph == 2'h2) begin
              d.sda_lo = 1'b0;
            end else begin
              d.op = CMD_NONE;
            end
          end
          CMD_WRITE, CMD_READ_ACK, CMD_READ_NACK, CMD_RECOVER: begin
            if (q.ph == 2'h0) begin
              if (q.op == CMD_WRITE && q.bit_i < BYTE_BITS) begin
                d.sda_lo = !q.tx[3'(4'h7 - q.bit_i)];
              end else begin
                d.sda_lo = (q.op == CMD_READ_ACK) && q.bit_i == BYTE_BITS;
              end
            end else if (q.ph == 2'h1) begin
              d.scl_lo = 1'b0;
            end else if (q.ph == 2'h2) begin
              if (q.op == CMD_WRITE && q.bit_i == BYTE_BITS) begin
                d.nack = sda_s;
              end else if (q.op != CMD_WRITE && q.bit_i < BYTE_BITS) begin
                d.rx = {q.rx[6:0], sda_s};
              end
              d.found = sda_s;
            end else begin
              d.scl_lo = 1'b1;
              d.bit_i  = 4'(q.bit_i + 4'h1);
              if (q.op == CMD_RECOVER) begin
                if (q.found || q.bit_i == 4'(RECOVER_CLOCKS - 4'h1)) begin
                  d.op    = CMD_START;
                  d.bit_i = 4'h0;
                end
              end else if (q.bit_i == BYTE_BITS) begin
                d.op = CMD_NONE;
              end
            end
          end
          default: begin
            d.op = CMD_NONE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '{op: CMD_NONE, default: '0};
    end else begin
      q <= d;
    end
  end

  assign bus.scl_m_o  = 1'b0;
  assign bus.scl_m_oe = q.scl_lo;
  assign bus.sda_m_o  = 1'b0;
  assign bus.sda_m_oe = q.sda_lo;
  assign bvalid       = q.bvalid;
  assign bresp        = q.bresp;
  assign rvalid       = q.rvalid;
  assign rresp        = q.rresp;
  assign rdata        = q.rdata;
endmodule : twi_master_ctrl

// >>> dv/temp_sensed_serial_memory_port_bench.sv
`timescale 1ns/1ps
module temp_sensed_serial_memory_port_bench
  import tsm_pkg::*;
;
  localparam int         CONV  = 200;
  localparam int         NVW   = 1000;
  localparam logic [7:0] DEV_W = {CTRL_CODE, 3'b101, 1'b0};
  localparam logic [7:0] DEV_R = DEV_W | 8'h01;
  logic aclk = 1'b0, aresetn = 1'b0, wp = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] awaddr = 4'h0, wstrb = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata, st;
  logic [12:0] temp_code = 13'h0000;
  logic awready, wready, bvalid, arready, rvalid, standby;
  logic [1:0] bresp, rresp, rsp;
  logic [6:0] lut_index;
  int failures = 0, compares = 0;

  always #2 aclk = ~aclk;
  twi_if bus ();
  tsm_device #(.CONV_CYC(CONV), .NV_CYC(NVW)) tsm_device_inst (.aclk(aclk), .aresetn(aresetn), .bus(bus),
    .select_bit_zero(1'b1), .select_bit_one(1'b0), .select_bit_two(1'b1), .wp(wp), .temp_code(temp_code),
    .lut_index(lut_index), .standby(standby));
  twi_master_ctrl #(.QUARTER(4)) twi_master_ctrl_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .bus(bus));
  twi_link_sva twi_link_sva_inst (.aclk(aclk), .aresetn(aresetn), .scl_m_o(bus.scl_m_o),
    .scl_m_oe(bus.scl_m_oe), .sda_m_o(bus.sda_m_o), .sda_m_oe(bus.sda_m_oe), .sda_d_o(bus.sda_d_o),
    .sda_d_oe(bus.sda_d_oe), .scl(bus.scl), .sda(bus.sda));

  // ----------
  // Access tasks
  // ----------
  task automatic give_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  task automatic hang;
    failures++;
    give_verdict();
  endtask : hang
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    rsp = bresp;
    bready <= 1'b0;
    if (n == 99) hang();
    @(posedge aclk);
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    st = rdata;
    rsp = rresp;
    rready <= 1'b0;
    if (n == 99) hang();
    @(posedge aclk);
  endtask : axi_rd
  task automatic op(input twi_cmd_e c, input logic [7:0] b = 8'h00);
    int n;
    axi_wr(CMD_OFFSET, {16'h0000, b, 5'h00, c});
    for (n = 0; n < 200; n++) begin
      axi_rd(STATUS_OFFSET);
      if (st[STATUS_BUSY_BIT] === 1'b0) break;
    end
    if (n == 200) hang();
  endtask : op
  task automatic stop;
    op(CMD_STOP);
    repeat (NVW + 20) @(posedge aclk);
  endtask : stop
  task automatic wr_page(input logic [7:0] a, input logic [7:0] v, input int n);
    int i;
    op(CMD_START);
    op(CMD_WRITE, DEV_W);
    check(st[STATUS_NACK_BIT], 1'b0);
    op(CMD_WRITE, a);
    for (i = 0; i < n; i++) begin
      op(CMD_WRITE, v + 8'(i));
      check(st[STATUS_NACK_BIT], 1'b0);
    end
  endtask : wr_page
  task automatic rd_cur(input int n, input logic [7:0] e);
    int i;
    op(CMD_START);
    op(CMD_WRITE, DEV_R);
    check(st[STATUS_NACK_BIT], 1'b0);
    for (i = 0; i < n; i++) begin
      op((i == n - 1) ? CMD_READ_NACK : CMD_READ_ACK);
      check(st[15:8], e + 8'(i));
    end
    stop();
    check(standby, 1'b1);
  endtask : rd_cur
  task automatic rd_at(input logic [7:0] a, input int n, input logic [7:0] e);
    op(CMD_START);
    op(CMD_WRITE, DEV_W);
    op(CMD_WRITE, a);
    rd_cur(n, e);
  endtask : rd_at

  // ----------
  // Tests
  // ----------
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    check(standby, 1'b1);
    axi_rd(4'h8);
    check(rsp, RESP_SLVERR);
    axi_wr(4'h8, 32'h0);
    check(rsp, RESP_SLVERR);
    temp_code <= 13'h191;
    repeat (40 * CONV) @(posedge aclk);
    rd_at(TEMP_HI_ADDR, 1, 8'h0C);
    rd_at(TEMP_LO_ADDR, 1, 8'h88);
    check(lut_index, 7'h20);
    temp_code <= 13'h180;
    repeat (5 * CONV) @(posedge aclk);
    check(lut_index, 7'h20);
    temp_code <= 13'h160;
    repeat (5 * CONV) @(posedge aclk);
    check(lut_index, 7'h1F);
    rd_at(TEMP_HI_ADDR, 1, 8'h0B);
    op(CMD_START);
    op(CMD_WRITE, DEV_W);
    op(CMD_WRITE, TEMP_HI_ADDR);
    temp_code <= 13'h191;
    repeat (5 * CONV) @(posedge aclk);
    check(lut_index, 7'h1F);
    check(standby, 1'b0);
    stop();
    check(lut_index, 7'h20);
    $display("test temperature done");
    wr_page(8'hFC, 8'hA0, 8);
    op(CMD_STOP);
    op(CMD_START);
    op(CMD_WRITE, DEV_W);
    check(st[STATUS_NACK_BIT], 1'b1);
    stop();
    rd_at(8'hFC, 1, 8'hA0);
    rd_cur(7, 8'hA1);
    $display("test page write done");
    wp <= 1'b1;
    wr_page(8'hFC, 8'h55, 1);
    stop();
    wp <= 1'b0;
    rd_at(8'hFC, 1, 8'hA0);
    wr_page(8'hFD, 8'h66, 1);
    rd_at(8'hFD, 1, 8'hA1);
    $display("test discard done");
    op(CMD_RECOVER);
    op(CMD_WRITE, DEV_W ^ 8'h04);
    check(st[STATUS_NACK_BIT], 1'b1);
    op(CMD_START);
    op(CMD_WRITE, DEV_W ^ 8'h40);
    check(st[STATUS_NACK_BIT], 1'b1);
    op(CMD_START);
    op(CMD_WRITE, DEV_W);
    check(st[STATUS_NACK_BIT], 1'b0);
    stop();
    check(standby, 1'b1);
    $display("test addressing done");
    give_verdict();
  end
endmodule : temp_sensed_serial_memory_port_bench

// >>> dv/twi_link_sva.sv
`timescale 1ns/1ps
module twi_link_sva (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Line drivers and levels
  input wire logic scl_m_o,
  input wire logic scl_m_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_d_o,
  input wire logic sda_d_oe,
  input wire logic scl,
  input wire logic sda
);
  // ----------
  // Line checks
  // ----------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence start_s;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence stop_s;
    scl && $past(scl) && $rose(sda);
  endsequence
  chk_dev_low_only: assert property (sda_d_oe |-> !sda_d_o) else $error("device drives data high");
  chk_mst_low_only: assert property (!(scl_m_oe && scl_m_o) && !(sda_m_oe && sda_m_o))
    else $error("master drives a line high");
  chk_dev_change_low: assert property ($changed(sda_d_oe) |-> !scl) else $error("device data moved in clock high");
  chk_mst_data_hold: assert property ($changed(sda_m_oe) && scl |-> $past(scl) ##1 scl)
    else $error("master data moved at clock edge");
  chk_scl_high_min: assert property ($rose(scl) |-> scl [*4]) else $error("clock high too short");
  chk_scl_low_min: assert property ($fell(scl) |-> !scl [*4]) else $error("clock low too short");
  chk_quiet_start: assert property (start_s |-> !sda_d_oe [*8]) else $error("device drives after start");
  chk_quiet_stop: assert property (stop_s |-> !sda_d_oe [*8]) else $error("device drives after stop");
endmodule : twi_link_sva
